// *** inc/vmon_defs.svh ***
/*
 * Register offsets (indices), reset values and bus constants for the
 * voltage and angle monitor bank.
 * Assumes inclusion by bare name from design files.
 */
`ifndef VMON_DEFS_SVH
`define VMON_DEFS_SVH

// printed offsets are not all word multiples: these are indices
`define IDX_SUPPLY_VOLTAGE 12'h474
`define IDX_PHASE_A_VOLTAGE 12'h47a
`define IDX_PHASE_B_VOLTAGE 12'h47c
`define IDX_PHASE_C_VOLTAGE 12'h47e
`define IDX_ANGLE_SINE 12'h4b6
`define IDX_ANGLE_COSINE 12'h4b8
`define MON_RESET_VALUE 32'h0000_0000
`define MON_FRAC_BITS 27
`define MON_FULL_SCALE_VOLTS 60
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10
`define RESP_DECERR 2'b11

`endif

// *** inc/vmon_pkg.sv ***
/*
 * Types shared by the monitor bank files.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package vmon_pkg;
    // one-hot read channel states
    typedef enum logic [1:0] {
        RD_IDLE = 2'b01,
        RD_RESP = 2'b10
    } rd_state_t;
    // one-hot write channel states
    typedef enum logic [2:0] {
        WR_IDLE = 3'b001,
        WR_COLLECT = 3'b010,
        WR_RESP = 3'b100
    } wr_state_t;
    // register selector
    typedef enum logic [2:0] {
        SEL_SUPPLY = 3'd0,
        SEL_PHASE_A = 3'd1,
        SEL_PHASE_B = 3'd2,
        SEL_PHASE_C = 3'd3,
        SEL_SINE = 3'd4,
        SEL_COSINE = 3'd5,
        SEL_NONE = 3'd7
    } reg_sel_t;
endpackage

// *** design/mon_word_latch.sv ***
/*
 * One monitoring word: captures a whole 32-bit sample on its strobe.
 * Assumes sample data and strobe come from logic on the same clock.
 */
`timescale 1ns/1ps
`default_nettype none
`include "vmon_defs.svh"
module mon_word_latch #(
    parameter int WIDTH = 32
) (
    input wire logic clk, // system clock
    input wire logic srst, // sync reset, high
    input wire logic load, // take new sample
    input wire logic [WIDTH-1:0] sample, // sample from control loop
    output logic [WIDTH-1:0] value // held word
);
    logic [WIDTH-1:0] word_reg;

    ////////////////////////////////////////////////////////////////////
    // whole word in one edge, so a read never sees halves
    always_ff @(posedge clk) begin
        if (srst) begin
            word_reg <= WIDTH'(`MON_RESET_VALUE);
        end else if (load) begin
            word_reg <= sample;
        end
    end
    assign value = word_reg;
endmodule
`default_nettype wire

// *** design/mon_addr_decode.sv ***
/*
 * Address decoder: byte address to register selector.
 * Assumes word aligned byte addresses, four times the register index.
 */
`timescale 1ns/1ps
`default_nettype none
`include "vmon_defs.svh"
module mon_addr_decode
    import vmon_pkg::*;
(
    input wire logic [13:0] addr, // byte address
    output reg_sel_t sel // decoded register
);
    function automatic logic hit(input logic [13:0] a, input logic [11:0] i);
        hit = (a == {i, 2'b00});
    endfunction

    // unmapped and misaligned fall to SEL_NONE
    assign sel = hit(addr, `IDX_SUPPLY_VOLTAGE) ? SEL_SUPPLY :
                 hit(addr, `IDX_PHASE_A_VOLTAGE) ? SEL_PHASE_A :
                 hit(addr, `IDX_PHASE_B_VOLTAGE) ? SEL_PHASE_B :
                 hit(addr, `IDX_PHASE_C_VOLTAGE) ? SEL_PHASE_C :
                 hit(addr, `IDX_ANGLE_SINE) ? SEL_SINE :
                 hit(addr, `IDX_ANGLE_COSINE) ? SEL_COSINE : SEL_NONE;
endmodule
`default_nettype wire

// *** design/voltage_angle_monitor_regs.sv ***
/*
 * Read-only monitor bank: supply, phase voltages and commutation angle
 * sine and cosine, all fixed point with 27 fraction bits, on AXI4-Lite.
 * Assumes the control loop drives samples and strobes on CLOCK.
 */
`timescale 1ns/1ps
`default_nettype none
`include "vmon_defs.svh"
module voltage_angle_monitor_regs
    import vmon_pkg::*;
(
    input wire logic CLOCK, // 50 MHz system clock
    input wire logic SRST, // sync reset, high
    // control loop samples
    input wire logic [31:0] SUPPLY_SAMPLE, // bus voltage code
    input wire logic SUPPLY_STROBE, // new bus voltage
    input wire logic [31:0] PHASE_A_SAMPLE, // phase A code
    input wire logic [31:0] PHASE_B_SAMPLE, // phase B code
    input wire logic [31:0] PHASE_C_SAMPLE, // phase C code
    input wire logic PHASE_STROBE, // new phase set
    input wire logic INITIAL_SPEED_DETECT, // detect phase active
    input wire logic [31:0] SINE_SAMPLE, // angle sine code
    input wire logic [31:0] COSINE_SAMPLE, // angle cosine code
    input wire logic ANGLE_STROBE, // new angle pair
    // AXI4-Lite slave
    input wire logic [13:0] AWADDR, // write address
    input wire logic [2:0] AWPROT, // unused protection
    input wire logic AWVALID, // write address valid
    output logic AWREADY, // write address ready
    input wire logic [31:0] WDATA, // write data, discarded
    input wire logic [3:0] WSTRB, // byte strobes, unused
    input wire logic WVALID, // write data valid
    output logic WREADY, // write data ready
    output logic [1:0] BRESP, // write response
    output logic BVALID, // write response valid
    input wire logic BREADY, // write response ready
    input wire logic [13:0] ARADDR, // read address
    input wire logic [2:0] ARPROT, // unused protection
    input wire logic ARVALID, // read address valid
    output logic ARREADY, // read address ready
    output logic [31:0] RDATA, // read data
    output logic [1:0] RRESP, // read response
    output logic RVALID, // read data valid
    input wire logic RREADY // read data ready
);
    logic [31:0] supply_value, pha_value, phb_value, phc_value;
    logic [31:0] sine_value, cosine_value;
    logic phase_load, unused_ok;
    reg_sel_t rd_sel, wr_sel;
    rd_state_t rd_state_reg, rd_state_next;
    wr_state_t wr_state_reg, wr_state_next;
    logic aw_seen_reg, w_seen_reg;
    logic [13:0] awaddr_reg, wr_addr;
    logic [31:0] rdata_reg, rdata_next;
    logic [1:0] rresp_reg, rresp_next, bresp_reg;
    logic arready_reg, awready_reg, wready_reg, rvalid_reg;
    logic ar_fire, aw_fire, w_fire, both_seen;

    assign unused_ok = ^{AWPROT, ARPROT, WDATA, WSTRB};

    ////////////////////////////////////////////////////////////////////
    // sample holding words, each loaded whole on its strobe
    // phase voltages only change while initial speed detect runs
    assign phase_load = PHASE_STROBE & INITIAL_SPEED_DETECT;

    mon_word_latch #(.WIDTH(32)) u_supply (
        .clk(CLOCK), .srst(SRST), .load(SUPPLY_STROBE),
        .sample(SUPPLY_SAMPLE), .value(supply_value));
    mon_word_latch #(.WIDTH(32)) u_pha (
        .clk(CLOCK), .srst(SRST), .load(phase_load),
        .sample(PHASE_A_SAMPLE), .value(pha_value));
    mon_word_latch #(.WIDTH(32)) u_phb (
        .clk(CLOCK), .srst(SRST), .load(phase_load),
        .sample(PHASE_B_SAMPLE), .value(phb_value));
    mon_word_latch #(.WIDTH(32)) u_phc (
        .clk(CLOCK), .srst(SRST), .load(phase_load),
        .sample(PHASE_C_SAMPLE), .value(phc_value));
    mon_word_latch #(.WIDTH(32)) u_sin (
        .clk(CLOCK), .srst(SRST), .load(ANGLE_STROBE),
        .sample(SINE_SAMPLE), .value(sine_value));
    mon_word_latch #(.WIDTH(32)) u_cos (
        .clk(CLOCK), .srst(SRST), .load(ANGLE_STROBE),
        .sample(COSINE_SAMPLE), .value(cosine_value));

    ////////////////////////////////////////////////////////////////////
    // address decoding
    mon_addr_decode u_rd_dec (.addr(ARADDR), .sel(rd_sel));
    // write side decodes the address as it is taken, or the held one
    assign wr_addr = aw_fire ? AWADDR : awaddr_reg;
    mon_addr_decode u_wr_dec (.addr(wr_addr), .sel(wr_sel));

    ////////////////////////////////////////////////////////////////////
    // read channel: one read at a time, answer one cycle after address
    assign ar_fire = ARVALID & arready_reg;
    assign rd_state_next = ar_fire ? RD_RESP :
        (rd_state_reg == RD_RESP && RREADY) ? RD_IDLE : rd_state_reg;
    // the whole word is registered at once: no split read
    assign rdata_next =
        (rd_sel == SEL_SUPPLY) ? supply_value :
        (rd_sel == SEL_PHASE_A) ? pha_value :
        (rd_sel == SEL_PHASE_B) ? phb_value :
        (rd_sel == SEL_PHASE_C) ? phc_value :
        (rd_sel == SEL_SINE) ? sine_value :
        (rd_sel == SEL_COSINE) ? cosine_value : 32'h0000_0000;
    assign rresp_next = (rd_sel == SEL_NONE) ? `RESP_DECERR : `RESP_OKAY;

    always_ff @(posedge CLOCK) begin
        if (SRST) begin
            rd_state_reg <= RD_IDLE;
            arready_reg <= 1'b0;
            rvalid_reg <= 1'b0;
            rdata_reg <= 32'h0000_0000;
            rresp_reg <= 2'b00;
        end else begin
            rd_state_reg <= rd_state_next;
            rvalid_reg <= (rd_state_next == RD_RESP);
            arready_reg <= (rd_state_next == RD_IDLE) && !ar_fire;
            if (ar_fire) begin
                rdata_reg <= rdata_next;
                rresp_reg <= rresp_next;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // write channel: address and data in either order, data dropped
    assign aw_fire = AWVALID & awready_reg;
    assign w_fire = WVALID & wready_reg;
    assign both_seen = (aw_seen_reg | aw_fire) & (w_seen_reg | w_fire);

    always_comb begin
        case (wr_state_reg)
            WR_IDLE, WR_COLLECT: begin
                wr_state_next = both_seen ? WR_RESP :
                    (aw_fire | w_fire) ? WR_COLLECT : wr_state_reg;
            end
            WR_RESP: begin
                wr_state_next = BREADY ? WR_IDLE : WR_RESP;
            end
            default: begin
                wr_state_next = WR_IDLE;
            end
        endcase
    end

    // writes to mapped words answer SLVERR: contents never change
    always_ff @(posedge CLOCK) begin
        if (SRST) begin
            wr_state_reg <= WR_IDLE;
            aw_seen_reg <= 1'b0;
            w_seen_reg <= 1'b0;
            awready_reg <= 1'b0;
            wready_reg <= 1'b0;
            awaddr_reg <= 14'h0000;
            bresp_reg <= 2'b00;
        end else begin
            wr_state_reg <= wr_state_next;
            if (aw_fire) begin
                awaddr_reg <= AWADDR;
            end
            aw_seen_reg <= (aw_seen_reg | aw_fire) & !both_seen;
            w_seen_reg <= (w_seen_reg | w_fire) & !both_seen;
            awready_reg <= (wr_state_next != WR_RESP) &&
                !(aw_seen_reg | aw_fire);
            wready_reg <= (wr_state_next != WR_RESP) &&
                !(w_seen_reg | w_fire);
            // answer code fixed as the write completes, held with bvalid
            if (both_seen) begin
                bresp_reg <= (wr_sel == SEL_NONE) ? `RESP_DECERR :
                    `RESP_SLVERR;
            end
        end
    end

    // write response valid from its own flop
    logic bvalid_reg;
    always_ff @(posedge CLOCK) begin
        if (SRST) begin
            bvalid_reg <= 1'b0;
        end else begin
            bvalid_reg <= (wr_state_next == WR_RESP);
        end
    end

    ////////////////////////////////////////////////////////////////////
    // outputs, all from flip-flops
    assign ARREADY = arready_reg;
    assign RVALID = rvalid_reg;
    assign RDATA = rdata_reg;
    assign RRESP = rresp_reg;
    assign AWREADY = awready_reg;
    assign WREADY = wready_reg;
    assign BVALID = bvalid_reg;
    assign BRESP = bresp_reg;

    ////////////////////////////////////////////////////////////////////
    // checks: words load whole on their strobe; supply and angle words hold without it, phase words hold outside speed detect
    AST_SUPPLY_LOAD: assert property (
        @(posedge CLOCK) disable iff (SRST)
        SUPPLY_STROBE |=> supply_value == $past(SUPPLY_SAMPLE))
        else $error("supply word did not load");
    AST_SUPPLY_HOLD: assert property (
        @(posedge CLOCK) disable iff (SRST)
        !SUPPLY_STROBE |=> $stable(supply_value))
        else $error("supply word changed without strobe");
    AST_PHASE_A_LOAD: assert property (
        @(posedge CLOCK) disable iff (SRST)
        phase_load |=> pha_value == $past(PHASE_A_SAMPLE))
        else $error("phase A word did not load");
    AST_PHASE_HOLD: assert property (
        @(posedge CLOCK) disable iff (SRST)
        !INITIAL_SPEED_DETECT |=> $stable(pha_value) && $stable(phb_value)
        && $stable(phc_value))
        else $error("phase word changed outside speed detect");
    AST_PHASE_B_LOAD: assert property (
        @(posedge CLOCK) disable iff (SRST)
        phase_load |=> phb_value == $past(PHASE_B_SAMPLE))
        else $error("phase B word did not load");
    AST_PHASE_C_LOAD: assert property (
        @(posedge CLOCK) disable iff (SRST)
        phase_load |=> phc_value == $past(PHASE_C_SAMPLE))
        else $error("phase C word did not load");
    AST_SINE_LOAD: assert property (
        @(posedge CLOCK) disable iff (SRST)
        ANGLE_STROBE |=> sine_value == $past(SINE_SAMPLE))
        else $error("sine word did not load");
    AST_SINE_HOLD: assert property (
        @(posedge CLOCK) disable iff (SRST)
        !ANGLE_STROBE |=> $stable(sine_value))
        else $error("sine word changed without strobe");
    AST_COSINE_LOAD: assert property (
        @(posedge CLOCK) disable iff (SRST)
        ANGLE_STROBE |=> cosine_value == $past(COSINE_SAMPLE))
        else $error("cosine word did not load");
    AST_COSINE_HOLD: assert property (
        @(posedge CLOCK) disable iff (SRST)
        !ANGLE_STROBE |=> $stable(cosine_value))
        else $error("cosine word changed without strobe");

    // checks: reset clears words and idles the bus
    AST_RESET_WORDS: assert property (
        @(posedge CLOCK)
        SRST |=> supply_value == '0 && pha_value == '0 && phb_value == '0
        && phc_value == '0 && sine_value == '0 && cosine_value == '0)
        else $error("monitor word not zero after reset");
    AST_RESET_BUS: assert property (
        @(posedge CLOCK)
        SRST |=> !RVALID && !BVALID && RDATA == 32'h0000_0000)
        else $error("bus outputs not idle after reset");

    // checks: reads return the snapshot taken at the address handshake
    AST_SUPPLY_READ: assert property (
        @(posedge CLOCK) disable iff (SRST)
        ar_fire && ARADDR == 14'h11d0 |=> RVALID && RRESP == 2'b00
        && RDATA == $past(supply_value))
        else $error("supply read wrong");
    AST_PHASE_A_READ: assert property (
        @(posedge CLOCK) disable iff (SRST)
        ar_fire && ARADDR == 14'h11e8 |=> RDATA == $past(pha_value))
        else $error("phase A read wrong");
    AST_PHASE_B_READ: assert property (
        @(posedge CLOCK) disable iff (SRST)
        ar_fire && ARADDR == 14'h11f0 |=> RDATA == $past(phb_value))
        else $error("phase B read wrong");
    AST_PHASE_C_READ: assert property (
        @(posedge CLOCK) disable iff (SRST)
        ar_fire && ARADDR == 14'h11f8 |=> RDATA == $past(phc_value))
        else $error("phase C read wrong");
    AST_SINE_READ: assert property (
        @(posedge CLOCK) disable iff (SRST)
        ar_fire && ARADDR == 14'h12d8 |=> RRESP == 2'b00
        && RDATA == $past(sine_value))
        else $error("sine read wrong");
    AST_COSINE_READ: assert property (
        @(posedge CLOCK) disable iff (SRST)
        ar_fire && ARADDR == 14'h12e0 |=> RRESP == 2'b00
        && RDATA == $past(cosine_value))
        else $error("cosine read wrong");
    AST_READ_STABLE: assert property (
        @(posedge CLOCK) disable iff (SRST)
        RVALID && !RREADY |=> RVALID && $stable(RDATA))
        else $error("read data changed while waiting");
    AST_READ_BUSY: assert property (
        @(posedge CLOCK) disable iff (SRST)
        RVALID |-> !ARREADY)
        else $error("read address taken while a read is outstanding");

    // checks: writes are refused and leave the sine and cosine words unchanged
    AST_WRITE_IGNORED: assert property (
        @(posedge CLOCK) disable iff (SRST)
        both_seen && !ANGLE_STROBE |=> BVALID && BRESP[1]
        && $stable(sine_value) && $stable(cosine_value))
        else $error("write not refused or changed a word");
    AST_WRITE_BUSY: assert property (
        @(posedge CLOCK) disable iff (SRST)
        BVALID |-> !AWREADY && !WREADY)
        else $error("write taken while a response is pending");
    AST_BRESP_STABLE: assert property (
        @(posedge CLOCK) disable iff (SRST)
        BVALID && !BREADY |=> BVALID && $stable(BRESP))
        else $error("write response changed while waiting");

    COV_READ: cover property (@(posedge CLOCK) ar_fire ##1 RVALID && RREADY);
    COV_WRITE: cover property (@(posedge CLOCK) BVALID && BREADY);
    COV_PHASE: cover property (@(posedge CLOCK) phase_load);
    COV_DECERR: cover property (@(posedge CLOCK) RVALID && RRESP == 2'b11);
    COV_STALL: cover property (@(posedge CLOCK) RVALID && !RREADY ##1 RREADY);
endmodule
`default_nettype wire

// *** verification/voltage_angle_monitor_regs_tb.sv ***
/*
 * Self-checking bench for the read-only monitor bank on AXI4-Lite.
 * Assumes the bank's own assertions run inside the design files.
 */
`timescale 1ns/1ps
`default_nettype none
`include "vmon_defs.svh"
module voltage_angle_monitor_regs_tb;
    typedef struct packed {logic [31:0] d; logic [1:0] r;} rd_exp_t;
    logic CLOCK = 1'b0, SRST = 1'b1;
    logic [31:0] SUPPLY_SAMPLE = '0, PHASE_A_SAMPLE = '0;
    logic [31:0] PHASE_B_SAMPLE = '0, PHASE_C_SAMPLE = '0;
    logic [31:0] SINE_SAMPLE = '0, COSINE_SAMPLE = '0, WDATA = '0;
    logic SUPPLY_STROBE = 1'b0, PHASE_STROBE = 1'b0, ANGLE_STROBE = 1'b0;
    logic INITIAL_SPEED_DETECT = 1'b0;
    logic [13:0] AWADDR = '0, ARADDR = '0;
    logic AWVALID = 1'b0, WVALID = 1'b0, BREADY = 1'b0;
    logic ARVALID = 1'b0, RREADY = 1'b0;
    logic AWREADY, WREADY, BVALID, ARREADY, RVALID;
    logic [1:0] BRESP, RRESP;
    logic [31:0] RDATA;
    logic [11:0] idx_tab [6] = '{`IDX_SUPPLY_VOLTAGE, `IDX_PHASE_A_VOLTAGE,
        `IDX_PHASE_B_VOLTAGE, `IDX_PHASE_C_VOLTAGE, `IDX_ANGLE_SINE,
        `IDX_ANGLE_COSINE};
    logic [31:0] wd [6];
    rd_exp_t q_rd [$];
    logic [1:0] q_b [$];
    int failures = 0, n_compared = 0, cycles = 0;

    voltage_angle_monitor_regs DUT (.CLOCK(CLOCK), .SRST(SRST),
        .SUPPLY_SAMPLE(SUPPLY_SAMPLE), .SUPPLY_STROBE(SUPPLY_STROBE),
        .PHASE_A_SAMPLE(PHASE_A_SAMPLE), .PHASE_B_SAMPLE(PHASE_B_SAMPLE),
        .PHASE_C_SAMPLE(PHASE_C_SAMPLE), .PHASE_STROBE(PHASE_STROBE),
        .INITIAL_SPEED_DETECT(INITIAL_SPEED_DETECT),
        .SINE_SAMPLE(SINE_SAMPLE), .COSINE_SAMPLE(COSINE_SAMPLE),
        .ANGLE_STROBE(ANGLE_STROBE), .AWADDR(AWADDR), .AWPROT(3'h0),
        .AWVALID(AWVALID), .AWREADY(AWREADY), .WDATA(WDATA),
        .WSTRB(4'hf), .WVALID(WVALID), .WREADY(WREADY), .BRESP(BRESP),
        .BVALID(BVALID), .BREADY(BREADY), .ARADDR(ARADDR), .ARPROT(3'h0),
        .ARVALID(ARVALID), .ARREADY(ARREADY), .RDATA(RDATA),
        .RRESP(RRESP), .RVALID(RVALID), .RREADY(RREADY));

    ////////////////////////////////////////////////////////////////////////
    // clock, watchdog and verdict
    initial begin
        forever #10 CLOCK = ~CLOCK;
    end

    task automatic results();
        if (failures == 0 && n_compared > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // generous ceiling: the whole run needs well under a thousand cycles
    always @(posedge CLOCK) begin
        cycles++;
        if (cycles == 5000) begin
            failures++;
            results();
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // monitors: compare each answer with the oldest note
    task automatic check(string name, logic [31:0] e, logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            failures++;
            $display("ERROR %s expected %h seen %h", name, e, g);
        end
    endtask

    always @(posedge CLOCK) begin
        if (RVALID === 1'b1 && RREADY === 1'b1) begin
            if (q_rd.size() == 0) begin
                check("unexpected read", 32'h0, 32'h1);
            end else begin
                check("rdata", q_rd[0].d, RDATA);
                check("rresp", {30'h0, q_rd[0].r}, {30'h0, RRESP});
                void'(q_rd.pop_front());
            end
        end
        if (BVALID === 1'b1 && BREADY === 1'b1) begin
            if (q_b.size() == 0) begin
                check("unexpected write", 32'h0, 32'h1);
            end else begin
                check("bresp", {30'h0, q_b.pop_front()}, {30'h0, BRESP});
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // bus and sample drivers; dly stalls rready to show rvalid stands
    task automatic rd(logic [11:0] idx, logic [31:0] ed, logic [1:0] er,
            int dly);
        q_rd.push_back(rd_exp_t'{ed, er});
        @(posedge CLOCK);
        ARADDR <= {idx, 2'b00};
        ARVALID <= 1'b1;
        do @(posedge CLOCK); while (ARREADY !== 1'b1);
        ARVALID <= 1'b0;
        repeat (dly) @(posedge CLOCK);
        RREADY <= 1'b1;
        do @(posedge CLOCK); while (RVALID !== 1'b1);
        RREADY <= 1'b0;
    endtask

    task automatic wr(logic [11:0] idx, logic [1:0] er);
        logic aw, w;
        q_b.push_back(er);
        aw = 1'b0;
        w = 1'b0;
        @(posedge CLOCK);
        AWADDR <= {idx, 2'b00};
        WDATA <= $urandom;
        AWVALID <= 1'b1;
        WVALID <= 1'b1;
        BREADY <= 1'b1;
        while (!(aw && w)) begin
            @(posedge CLOCK);
            if (!aw && AWREADY === 1'b1) begin
                aw = 1'b1;
                AWVALID <= 1'b0;
            end
            if (!w && WREADY === 1'b1) begin
                w = 1'b1;
                WVALID <= 1'b0;
            end
        end
        do @(posedge CLOCK); while (BVALID !== 1'b1);
        BREADY <= 1'b0;
    endtask

    // k: 0 supply, 1 phase set, 2 angle pair; det is the detect level
    task automatic strobe(int k, logic det);
        logic [31:0] a, b, c;
        a = $urandom;
        b = $urandom;
        c = $urandom;
        @(posedge CLOCK);
        if (k == 0) begin
            SUPPLY_SAMPLE <= a;
            SUPPLY_STROBE <= 1'b1;
            wd[0] = a;
        end else if (k == 1) begin
            PHASE_A_SAMPLE <= a;
            PHASE_B_SAMPLE <= b;
            PHASE_C_SAMPLE <= c;
            PHASE_STROBE <= 1'b1;
            INITIAL_SPEED_DETECT <= det;
            if (det) begin
                wd[1] = a;
                wd[2] = b;
                wd[3] = c;
            end
        end else begin
            SINE_SAMPLE <= a;
            COSINE_SAMPLE <= b;
            ANGLE_STROBE <= 1'b1;
            wd[4] = a;
            wd[5] = b;
        end
        @(posedge CLOCK);
        {SUPPLY_STROBE, PHASE_STROBE, ANGLE_STROBE} <= 3'b000;
        INITIAL_SPEED_DETECT <= 1'b0;
    endtask

    task automatic do_reset();
        SRST <= 1'b1;
        repeat (5) @(posedge CLOCK);
        SRST <= 1'b0;
        foreach (wd[i]) wd[i] = 32'h0;
        repeat (2) @(posedge CLOCK);
    endtask

    ////////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        int d;
        void'($urandom(48129));
        do_reset();
        foreach (idx_tab[i]) rd(idx_tab[i], 32'h0, `RESP_OKAY, 0);
        for (int k = 0; k < 3; k++) strobe(k, 1'b1);
        foreach (idx_tab[i]) begin
            d = $urandom_range(3);
            rd(idx_tab[i], wd[i], `RESP_OKAY, d);
        end
        strobe(1, 1'b0);
        for (int i = 1; i < 4; i++) rd(idx_tab[i], wd[i], `RESP_OKAY, 0);
        foreach (idx_tab[i]) begin
            wr(idx_tab[i], `RESP_SLVERR);
            rd(idx_tab[i], wd[i], `RESP_OKAY, 0);
        end
        wr(12'h476, `RESP_DECERR);
        rd(12'h476, 32'h0, `RESP_DECERR, 1);
        // a new sample landing under a stalled read must not leak into it
        fork
            rd(idx_tab[0], wd[0], `RESP_OKAY, 3);
            begin
                repeat (2) @(posedge CLOCK);
                strobe(0, 1'b1);
            end
        join
        rd(idx_tab[0], wd[0], `RESP_OKAY, 0);
        strobe(2, 1'b1);
        do_reset();
        foreach (idx_tab[i]) rd(idx_tab[i], 32'h0, `RESP_OKAY, 0);
        repeat (3) @(posedge CLOCK);
        check("pending notes", 32'h0, q_rd.size() + q_b.size());
        results();
    end
endmodule
`default_nettype wire
